// file: core/twbf_core.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - Data line changes only while clock low; stable while clock high.
// - Data change during clock high is a bus condition, never data.
// - Data falling while clock high is a start; device detects it.
// - Data rising while clock high is a stop; device detects it.
// - Stop after a read returns device to standby, data released.
// - Every word is exactly eight bits, one per clock pulse.
// - Device pulls data low on ninth clock to acknowledge each word it receives, unless the address mismatches or a write is running.
// - Standby at power-up, and after stop once internal write finishes.
// - Self-timed write finishes within 10 ms after the ending stop.
// - Device only pulls data low or releases it.
// - During internal write, no acknowledge to any bus traffic.
// - Address mismatch withholds acknowledge; standby until next start.
module twbf_core
  import twbf_pkg::*;
#(
  parameter int unsigned TWR_CYC = TWR_CYCLES
) (
  input  wire logic       I_CLK,
  input  wire logic       I_RESETN,
  input  wire logic       I_SCL,
  input  wire logic       I_SDA,
  output var  logic       O_SDA,
  output var  logic       O_SDA_OE,
  input  wire logic [2:0] I_ADDR_SEL,
  input  wire logic [7:0] I_TX_DATA,
  output var  logic [7:0] O_RX_DATA,
  output var  logic       O_RX_VALID,
  output var  logic       O_RX_IS_ADDR,
  output var  logic       O_TX_TAKEN,
  output var  logic       O_READ_MODE,
  output var  logic       O_STANDBY,
  output var  logic       O_WRITE_BUSY,
  output var  logic       O_START,
  output var  logic       O_STOP
);
  // ---------------------------------------------------------------
  // Pin sampling and edge detection
  // ---------------------------------------------------------------
  logic scl_s;
  logic sda_s;
  logic scl_d_r;
  logic sda_d_r;

  twbf_sync #(.RST_VAL(1'b1)) u_scl_sync (
    .i_clk    (I_CLK),
    .i_resetn (I_RESETN),
    .i_d      (I_SCL),
    .o_q      (scl_s)
  );
  twbf_sync #(.RST_VAL(1'b1)) u_sda_sync (
    .i_clk    (I_CLK),
    .i_resetn (I_RESETN),
    .i_d      (I_SDA),
    .o_q      (sda_s)
  );

  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  // Data edges with clock high are conditions only
  wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ---------------------------------------------------------------
  // Framing state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TWBF_IDLE,
    TWBF_RX,
    TWBF_RX_ACK,
    TWBF_TX,
    TWBF_TX_ACK
  } twbf_state_t;

  twbf_state_t state_r;
  twbf_state_t state_nxt;
  logic [3:0]  bit_cnt_r;
  logic [3:0]  bit_cnt_nxt;
  logic [7:0]  shift_r;
  logic [7:0]  shift_nxt;
  logic        first_r;
  logic        read_r;
  logic        wrote_r;
  logic        drive_r;
  logic [31:0] twr_cnt_r;
  logic        busy_r;
  logic        sel_r;
  logic [2:0]  sel_lat_r;
  // Address straps caught after reset release
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sel_r     <= 1'b0;
      sel_lat_r <= SEL_RESET;
    end else if (!sel_r) begin
      sel_r     <= 1'b1;
      sel_lat_r <= I_ADDR_SEL;
    end
  end

  wire       word_done  = scl_rise && (bit_cnt_r == 4'(WORD_BITS - 1));
  wire [7:0] rx_word    = {shift_r[6:0], sda_s};
  wire       rx_word_r0 = shift_r[0];   // R/W bit while the address word is held
  wire       addr_match = (rx_word[7:4] == ADDR_PREFIX) && (rx_word[3:1] == sel_lat_r);
  // No acknowledge while the internal write runs
  wire       ack_ok     = first_r ? (addr_match && !busy_r) : 1'b1;
  wire       tx_ack_hi  = scl_rise && sda_s;
  wire       in_ack     = (state_r == TWBF_RX_ACK);
  // Next-state decode
  always_comb begin
    state_nxt   = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt   = shift_r;
    if (start_det) begin
      state_nxt   = TWBF_RX;
      bit_cnt_nxt = 4'h0;
    end else if (stop_det) begin
      state_nxt   = TWBF_IDLE;
      bit_cnt_nxt = 4'h0;
    end else begin
      unique case (state_r)
        TWBF_IDLE: state_nxt = TWBF_IDLE;
        TWBF_RX: begin
          if (scl_rise) begin
            shift_nxt   = rx_word;
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end
          if (word_done)
            state_nxt = ack_ok ? TWBF_RX_ACK : TWBF_IDLE;
        end
        TWBF_RX_ACK: begin
          // Ninth pulse ends on its falling edge
          if (scl_fall && bit_cnt_r == 4'(ACK_BIT)) begin
            bit_cnt_nxt = 4'h0;
            state_nxt   = (first_r && rx_word_r0) ? TWBF_TX : TWBF_RX;
            shift_nxt   = (first_r && rx_word_r0) ? I_TX_DATA : shift_r;
          end else if (scl_rise)
            bit_cnt_nxt = 4'(ACK_BIT);
        end
        TWBF_TX: begin
          if (scl_fall && bit_cnt_r != 4'h0)
            shift_nxt = {shift_r[6:0], 1'b1};
          if (scl_rise)
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          if (scl_fall && bit_cnt_r == 4'(WORD_BITS))
            state_nxt = TWBF_TX_ACK;
        end
        TWBF_TX_ACK: begin
          // Controller ack continues; no ack goes to idle until the next start
          if (tx_ack_hi)
            state_nxt = TWBF_IDLE;
          else if (scl_fall && bit_cnt_r == 4'(ACK_BIT)) begin
            state_nxt   = TWBF_TX;
            bit_cnt_nxt = 4'h0;
            shift_nxt   = I_TX_DATA;
          end else if (scl_rise)
            bit_cnt_nxt = 4'(ACK_BIT);
        end
        default: state_nxt = TWBF_IDLE;
      endcase
    end
  end

  // Framing registers; pin copies idle high so reset shows no false edge
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      scl_d_r   <= 1'b1;
      sda_d_r   <= 1'b1;
      state_r   <= TWBF_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'hFF;
    end else begin
      scl_d_r   <= scl_s;
      sda_d_r   <= sda_s;
      state_r   <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r   <= shift_nxt;
    end
  end
  // Address word flag and direction
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      first_r <= 1'b0;
      read_r  <= 1'b0;
      wrote_r <= 1'b0;
    end else if (start_det) begin
      first_r <= 1'b1;
      read_r  <= 1'b0;
      wrote_r <= 1'b0;
    end else if (in_ack && scl_fall && bit_cnt_r == 4'(ACK_BIT)) begin
      if (first_r) begin
        read_r <= shift_r[0];
      end else begin
        wrote_r <= 1'b1;          // A data word means write pending
      end
      first_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Self-timed write cycle
  // ---------------------------------------------------------------
  // Count always runs to the end; start, stop and address words are still seen but get no acknowledge
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      busy_r    <= 1'b0;
      twr_cnt_r <= '0;
    end else if (busy_r) begin
      if (twr_cnt_r == 32'(TWR_CYC - 1)) begin
        busy_r <= 1'b0;
      end
      twr_cnt_r <= twr_cnt_r + 32'h0000_0001;
    end else if (stop_det && wrote_r && !read_r) begin
      busy_r    <= 1'b1;
      twr_cnt_r <= '0;
    end
  end

  // ---------------------------------------------------------------
  // Open-drain data driver
  // ---------------------------------------------------------------
  // Drive changes follow the clock falling edge; start and stop also release it
  wire drive_nxt = (state_nxt == TWBF_RX_ACK)
                 || (state_nxt == TWBF_TX && !shift_nxt[7] && bit_cnt_nxt != 4'(WORD_BITS));
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      drive_r <= 1'b0;
    end else if (start_det || stop_det) begin
      drive_r <= 1'b0;
    end else if (scl_fall || state_nxt == TWBF_IDLE) begin
      drive_r <= drive_nxt && state_nxt != TWBF_IDLE;
    end
  end
  assign O_SDA    = 1'b0;
  assign O_SDA_OE = drive_r;

  // ---------------------------------------------------------------
  // User side strobes
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_RX_DATA    <= 8'h00;
      O_RX_VALID   <= 1'b0;
      O_RX_IS_ADDR <= 1'b0;
      O_TX_TAKEN   <= 1'b0;
      O_START      <= 1'b0;
      O_STOP       <= 1'b0;
    end else begin
      O_RX_VALID   <= state_r == TWBF_RX && word_done && ack_ok;
      O_RX_IS_ADDR <= first_r;
      if (state_r == TWBF_RX && word_done)
        O_RX_DATA <= rx_word;
      O_TX_TAKEN   <= state_r != TWBF_TX && state_nxt == TWBF_TX;
      O_START      <= start_det;
      O_STOP       <= stop_det;
    end
  end
  assign O_READ_MODE  = read_r;
  assign O_WRITE_BUSY = busy_r;
  assign O_STANDBY    = (state_r == TWBF_IDLE) && !busy_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  busy_no_ack_a : assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    busy_r && first_r && state_r == TWBF_RX |=> state_r != TWBF_RX_ACK)
    else $error("acknowledge given during write cycle");
  stop_release_a : assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    stop_det |=> !drive_r && state_r == TWBF_IDLE)
    else $error("stop did not release data line");
  start_abort_a : assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    start_det |=> bit_cnt_r == 4'h0 && !drive_r)
    else $error("start did not reset framing");
  ack_drive_a : assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    in_ack && bit_cnt_r == 4'(ACK_BIT) && scl_s |-> drive_r)
    else $error("ninth clock not acknowledged");
  count_range_a : assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    bit_cnt_r <= 4'(ACK_BIT))
    else $error("bit count out of range");
  drive_scl_low_a : assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    scl_s && scl_d_r && !start_det && !stop_det |=> $stable(drive_r))
    else $error("data drive changed while clock high");
  write_end_a : assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    busy_r |-> twr_cnt_r < 32'(TWR_CYC))
    else $error("write cycle overran");
  mismatch_a : assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    state_r == TWBF_RX && word_done && first_r && !addr_match
    |=> state_r == TWBF_IDLE)
    else $error("mismatch did not return to standby");
endmodule
`default_nettype wire

// file: core/twbf_pkg.sv
package twbf_pkg;
  // ---------------------------------------------------------------
  // Word framing
  // ---------------------------------------------------------------
  localparam int unsigned WORD_BITS   = 8;
  localparam int unsigned ACK_BIT     = 9;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned TWR_MS      = 10;
  // Longest time rounds down
  localparam int unsigned TWR_CYCLES  = (CLK_HZ / 1000) * TWR_MS;
  // Address word compare: fixed 1010 prefix in upper nibble
  localparam logic [3:0]  ADDR_PREFIX = 4'hA;
  localparam logic [2:0]  SEL_RESET   = 3'h0;
endpackage

// file: core/twbf_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// Two-flop synchroniser
// ---------------------------------------------------------------
module twbf_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_d,
  output var  logic o_q
);
  logic meta_r;
  // First stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_r <= RST_VAL;
      o_q    <= RST_VAL;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: dv/twbf_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// Bus controller model: bit-banged, 8 system clocks per bus clock
// One fixed bus rate, never faster than the device's 3-clock sampling
// ---------------------------------------------------------------
module twbf_ctrl (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda_low
);
  // Idle bus: clock parked high, data released to the pull-up
  initial begin
    o_scl = 1'h1;
    o_sda_low = 1'h0;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Data moves mid-low only, held through the high phase
  task automatic bit_out(input logic b);
    cyc(2);
    o_sda_low = ~b;
    cyc(2);
    o_scl = 1'h1;
    cyc(4);
    o_scl = 1'h0;
  endtask
  // Release data and sample it in mid-high
  task automatic bit_in(output logic b);
    cyc(2);
    o_sda_low = 1'h0;
    cyc(2);
    o_scl = 1'h1;
    cyc(2);
    b = i_sda;
    cyc(2);
    o_scl = 1'h0;
  endtask
  // Data falls while clock high, also usable as a repeated start
  task automatic start();
    cyc(2);
    o_sda_low = 1'h0;
    cyc(2);
    o_scl = 1'h1;
    cyc(4);
    o_sda_low = 1'h1;
    cyc(4);
    o_scl = 1'h0;
  endtask
  // Data rises while clock high; bus left idle
  task automatic stop();
    cyc(2);
    o_sda_low = 1'h1;
    cyc(2);
    o_scl = 1'h1;
    cyc(4);
    o_sda_low = 1'h0;
    cyc(4);
  endtask
  // Whole word MSB first, ninth pulse reads the acknowledge
  task automatic wr(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(b);
    ack = ~b;
  endtask
  task automatic rd(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bit_in(d[i]);
    end
  endtask
  // Nine pulses with data released, then a start
  task automatic recover();
    logic b;
    o_scl = 1'h0;
    for (int i = 0; i < 9; i++) begin
      bit_in(b);
    end
    start();
  endtask
endmodule
`default_nettype wire

// file: dv/two_wire_eeprom_bus_framing_test.sv
`timescale 1ns/10ps
`default_nettype none
module two_wire_eeprom_bus_framing_test;
  import twbf_pkg::*;
  // Short write cycle keeps the run brief
  localparam int unsigned TWR = 200;
  logic       i_clk, i_resetn, scl, sda, sda_low, oe, o_sda, ack;
  logic [2:0] sel;
  logic [7:0] tx, d, got, rx_data, last_rx;
  logic       rxv, is_addr, tkn, rmode, stby, busy, st, sp, last_addr;
  int         seed, error_cnt, num_checks, n_start, n_stop, n_rxv, n_tkn, cycles;
  // Open-drain wire with pull-up
  assign sda = ~sda_low & (oe ? o_sda : 1'h1);
  twbf_core #(.TWR_CYC(TWR)) twbf_core_i (.I_CLK(i_clk), .I_RESETN(i_resetn),
    .I_SCL(scl), .I_SDA(sda), .O_SDA(o_sda), .O_SDA_OE(oe), .I_ADDR_SEL(sel),
    .I_TX_DATA(tx), .O_RX_DATA(rx_data), .O_RX_VALID(rxv), .O_RX_IS_ADDR(is_addr),
    .O_TX_TAKEN(tkn), .O_READ_MODE(rmode), .O_STANDBY(stby), .O_WRITE_BUSY(busy),
    .O_START(st), .O_STOP(sp));
  twbf_ctrl twbf_ctrl_i (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  initial begin
    i_clk = 1'h0;
    forever #12.5 i_clk = ~i_clk;
  end
  // Pulse counters and timeout, a hang counts as an error
  always @(posedge i_clk) begin
    cycles++;
    if (st === 1'h1) n_start++;
    if (sp === 1'h1) n_stop++;
    if (tkn === 1'h1) n_tkn++;
    if (rxv === 1'h1) begin
      n_rxv++;
      last_rx = rx_data;
      last_addr = is_addr;
    end
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  function automatic logic [7:0] addr_word(input logic [2:0] s, input logic rw);
    return {ADDR_PREFIX, s, rw};
  endfunction
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    seed = 32'hc2fd_fa62;
    sel = 3'($random(seed));
    tx = 8'h00;
    i_resetn = 1'h0;
    twbf_ctrl_i.cyc(8);
    i_resetn = 1'h1;
    twbf_ctrl_i.cyc(4);
    chk("standby", stby, 8'h01);
    chk("oe", oe, 8'h00);
    // Word with no start before it is ignored
    twbf_ctrl_i.o_scl = 1'h0;
    twbf_ctrl_i.wr(addr_word(sel, 1'h0), ack);
    chk("nostart_ack", ack, 8'h00);
    chk("nostart_rxv", n_rxv, 8'h00);
    twbf_ctrl_i.stop();
    // Recovery, then a start that cuts a half word short
    twbf_ctrl_i.recover();
    for (int i = 0; i < 4; i++) twbf_ctrl_i.bit_out(1'($random(seed)));
    twbf_ctrl_i.start();
    chk("starts", n_start, 8'h02);
    twbf_ctrl_i.wr(addr_word(sel, 1'h0), ack);
    chk("addr_ack", ack, 8'h01);
    chk("addr_rx", last_rx, addr_word(sel, 1'h0));
    chk("addr_flag", last_addr, 8'h01);
    for (int k = 0; k < 3; k++) begin
      d = 8'($random(seed));
      twbf_ctrl_i.wr(d, ack);
      chk("data_ack", ack, 8'h01);
      chk("data_rx", last_rx, d);
      chk("data_flag", last_addr, 8'h00);
    end
    twbf_ctrl_i.stop();
    // The stop on the idle bus after the ignored word counts as well
    chk("stops", n_stop, 8'h02);
    chk("busy", busy, 8'h01);
    chk("standby_busy", stby, 8'h00);
    // Polling during the write cycle gets no acknowledge
    twbf_ctrl_i.start();
    twbf_ctrl_i.wr(addr_word(sel, 1'h0), ack);
    chk("poll_ack", ack, 8'h00);
    twbf_ctrl_i.stop();
    for (int i = 0; i < TWR + 50 && stby !== 1'h1; i++) twbf_ctrl_i.cyc(1);
    chk("write_done", {busy, stby}, 8'h01);
    // Wrong straps: no acknowledge, following words ignored
    twbf_ctrl_i.start();
    twbf_ctrl_i.wr(addr_word(sel ^ 3'h1, 1'h0), ack);
    chk("miss_ack", ack, 8'h00);
    twbf_ctrl_i.wr(8'($random(seed)), ack);
    chk("miss_data", ack, 8'h00);
    twbf_ctrl_i.stop();
    // Sequential read of two words, ended by no acknowledge
    twbf_ctrl_i.start();
    d = 8'($random(seed));
    tx = d;
    twbf_ctrl_i.wr(addr_word(sel, 1'h1), ack);
    chk("rd_ack", ack, 8'h01);
    // Direction settles a few clocks after the ninth falling edge
    twbf_ctrl_i.cyc(3);
    chk("rd_mode", rmode, 8'h01);
    twbf_ctrl_i.rd(got);
    chk("rd_word0", got, d);
    d = 8'($random(seed));
    tx = d;
    twbf_ctrl_i.bit_out(1'h0);
    twbf_ctrl_i.rd(got);
    chk("rd_word1", got, d);
    twbf_ctrl_i.bit_out(1'h1);
    twbf_ctrl_i.stop();
    chk("rd_end", {stby, oe, busy}, 8'h04);
    chk("tx_taken", n_tkn, 8'h02);
    end_of_test();
  end
endmodule
`default_nettype wire
